// *** design/osc_edge_counter.v ***
// Counts oscillator edges while a run level holds and flags a reached target
`timescale 1ns/10ps
`default_nettype none

module osc_edge_counter #(
  parameter WIDTH = 17
) (
  // Clock and reset
  input  wire             pclk,
  input  wire             presetn,
  // Control
  input  wire             run,
  input  wire             osc_edge,
  input  wire [WIDTH-1:0] target,
  // Result
  output reg              done
);

  reg [WIDTH-1:0] count;

  // Count restarts whenever run drops, so each request waits afresh
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= {WIDTH{1'b0}};
      done  <= 1'b0;
    end else if (!run) begin
      count <= {WIDTH{1'b0}};
      done  <= 1'b0;
    end else if (!done) begin
      if (osc_edge) begin
        count <= count + {{(WIDTH-1){1'b0}}, 1'b1};
        if (count + {{(WIDTH-1){1'b0}}, 1'b1} >= target) begin
          done <= 1'b1;
        end
      end
      if (target == {WIDTH{1'b0}}) begin
        done <= 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

// *** design/sleep_and_crystal_osc_control.v ***
// Sleep controller with clock gating and crystal oscillator control
`timescale 1ns/10ps
`default_nettype none
`include "sleep_defs.vh"

module sleep_and_crystal_osc_control #(
  parameter NREQ        = 4,
  parameter STARTUP_1K  = `XC_STARTUP_1K,
  parameter STARTUP_16K = `XC_STARTUP_16K,
  parameter STARTUP_32K = `XC_STARTUP_32K,
  parameter STARTUP_64K = `XC_STARTUP_64K
) (
  // Clock and reset
  input  wire            pclk,
  input  wire            presetn,
  // APB slave
  input  wire            psel,
  input  wire            penable,
  input  wire            pwrite,
  input  wire [7:0]      paddr,
  input  wire [31:0]     pwdata,
  output reg  [31:0]     prdata,
  output reg             pready,
  output reg             pslverr,
  // CPU side
  input  wire            sleep_instr,
  input  wire            any_irq,
  input  wire            debug_break,
  output reg             cpu_clk_en,
  output reg             cpu_resume,
  // Wake sources
  input  wire            pin_irq,
  input  wire            addr_match_irq,
  input  wire            timer_b_irq,
  input  wire            uart_sof_irq,
  input  wire            touch_window_irq,
  input  wire            rtc_irq,
  // Touch controller
  input  wire            touch_event,
  output reg             touch_start,
  // Clock domain enables
  output reg             per_clk_en,
  output reg             rtc_clk_en,
  output reg             touch_clk_en,
  output reg             watchdog_clk_en,
  output reg             main_osc_en,
  output reg             rtc_osc_en,
  input  wire            main_osc_ready,
  // Low-power oscillator
  input  wire            lp_osc_clk,
  input  wire            lp_osc_req,
  output reg             lp_osc_gate,
  // Crystal oscillator
  input  wire            crystal_pin_in,
  input  wire [NREQ-1:0] crystal_req,
  output reg  [NREQ-1:0] crystal_grant,
  output reg             crystal_osc_run,
  output reg             crystal_pins_override
);

  localparam ST_ACTIVE   = 2'h0;
  localparam ST_SLEEPING = 2'h1;
  localparam ST_WAKING   = 2'h2;

  // Registers
  reg            sleep_arm;
  reg  [1:0]     sleep_mode_select;
  reg            keep_running_in_standby;
  reg            crystal_enable;
  reg            standby_run_enable;
  reg            crystal_source_sel;
  reg  [1:0]     crystal_startup_select;
  reg  [3:0]     periph_standby_run;
  reg  [2:0]     unlock_count;

  // Sleep state
  reg  [1:0]     state;
  reg  [1:0]     next_state;
  reg  [1:0]     active_mode;
  reg  [2:0]     wake_count;

  // Synchronisers and edge detect
  reg  [2:0]     xc_sync;
  reg  [2:0]     lp_sync;
  reg  [1:0]     mor_sync;
  reg  [1:0]     brk_sync;

  wire           xc_edge = xc_sync[1] & ~xc_sync[2];
  wire           lp_edge = lp_sync[1] & ~lp_sync[2];
  wire           main_ready = mor_sync[1];
  wire           break_seen = brk_sync[1];
  wire           crystal_osc_stable;
  wire           crystal_gate_open;
  wire           lp_done;
  wire [16:0]    startup_target;
  wire           any_req = |crystal_req;
  wire           wr_access = psel & penable & pready & pwrite;
  wire           unlocked = (unlock_count != 3'h0);
  wire           sleeping = (state == ST_SLEEPING);
  wire           in_idle = sleeping & (active_mode == `MODE_IDLE);
  wire           in_standby = sleeping & (active_mode == `MODE_STANDBY);
  wire           in_power_down_mode = sleeping & (active_mode == `MODE_POWER_DOWN);
  wire           wake_event;
  reg  [31:0]    next_rdata;
  reg            next_err;

  function is_valid_mode;
    input [1:0] m;
    begin
      is_valid_mode = (m == `MODE_IDLE) | (m == `MODE_STANDBY) | (m == `MODE_POWER_DOWN);
    end
  endfunction

  function [16:0] startup_cycles;
    input [1:0] sel;
    begin
      case (sel)
        2'h0:    startup_cycles = STARTUP_1K[16:0];
        2'h1:    startup_cycles = STARTUP_16K[16:0];
        2'h2:    startup_cycles = STARTUP_32K[16:0];
        default: startup_cycles = STARTUP_64K[16:0];
      endcase
    end
  endfunction

  // Pin inputs pass two flops before any logic reads them
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xc_sync  <= 3'h0;
      lp_sync  <= 3'h0;
      mor_sync <= 2'h0;
      brk_sync <= 2'h0;
    end else begin
      xc_sync  <= {xc_sync[1:0], crystal_pin_in};
      lp_sync  <= {lp_sync[1:0], lp_osc_clk};
      mor_sync <= {mor_sync[0], main_osc_ready};
      brk_sync <= {brk_sync[0], debug_break};
    end
  end

  // APB read mux and unmapped answer
  always @* begin
    next_rdata = 32'h0;
    next_err   = 1'b0;
    case (paddr)
      `OFF_SLEEP_CTRL: begin
        next_rdata[`SLP_ARM_BIT] = sleep_arm;
        next_rdata[`SLP_MODE_HI:`SLP_MODE_LO] = sleep_mode_select;
      end
      `OFF_PROTECT_KEY: next_rdata[0] = unlocked;
      `OFF_CLOCK_STATUS: begin
        next_rdata[`ST_CRYSTAL_BIT] = crystal_osc_stable;
        next_rdata[`ST_LP_BIT] = lp_done;
      end
      `OFF_LP_OSC_CTRL: next_rdata[`LP_RUN_BIT] = keep_running_in_standby;
      `OFF_CRYSTAL_CTRL: begin
        next_rdata[`XC_ENABLE_BIT] = crystal_enable;
        next_rdata[`XC_RUN_BIT] = standby_run_enable;
        next_rdata[`XC_SEL_BIT] = crystal_source_sel;
        next_rdata[`XC_SUT_HI:`XC_SUT_LO] = crystal_startup_select;
      end
      `OFF_STANDBY_RUN: next_rdata[3:0] = periph_standby_run;
      `OFF_SLEEP_STATUS: next_rdata[3:0] = {active_mode, state};
      default: next_err = 1'b1;
    endcase
  end

  // APB handshake: one wait-free access phase per transfer
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      if (psel & ~penable) begin
        prdata  <= pwrite ? 32'h0 : next_rdata;
        pslverr <= next_err;
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

  // Register writes
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sleep_arm               <= 1'b0;
      sleep_mode_select       <= `MODE_IDLE;
      keep_running_in_standby <= 1'b0;
      crystal_enable          <= 1'b0;
      standby_run_enable      <= 1'b0;
      crystal_source_sel      <= 1'b0;
      crystal_startup_select  <= 2'h0;
      periph_standby_run      <= 4'h0;
      unlock_count            <= 3'h0;
    end else begin
      if (unlocked) begin
        unlock_count <= unlock_count - 3'h1;
      end
      if (wr_access) begin
        case (paddr)
          `OFF_SLEEP_CTRL: begin
            sleep_arm         <= pwdata[`SLP_ARM_BIT];
            sleep_mode_select <= pwdata[`SLP_MODE_HI:`SLP_MODE_LO];
          end
          `OFF_PROTECT_KEY: begin
            if (pwdata[7:0] == `PROTECT_KEY) begin
              unlock_count <= `PROTECT_WINDOW;
            end
          end
          `OFF_LP_OSC_CTRL: begin
            if (unlocked) begin
              keep_running_in_standby <= pwdata[`LP_RUN_BIT];
            end
          end
          `OFF_CRYSTAL_CTRL: begin
            if (unlocked) begin
              crystal_enable     <= pwdata[`XC_ENABLE_BIT];
              standby_run_enable <= pwdata[`XC_RUN_BIT];
              unlock_count       <= 3'h0;
            end
            if (!crystal_enable && !crystal_osc_stable) begin
              crystal_source_sel     <= pwdata[`XC_SEL_BIT];
              crystal_startup_select <= pwdata[`XC_SUT_HI:`XC_SUT_LO];
            end
          end
          `OFF_STANDBY_RUN: periph_standby_run <= pwdata[3:0];
          default: ;
        endcase
      end
    end
  end

  // Wake sources per mode
  assign wake_event = (in_idle & any_irq)
                    | (in_standby & (pin_irq | addr_match_irq | timer_b_irq))
                    | (in_standby & periph_standby_run[`SR_UART_BIT] & uart_sof_irq)
                    | (in_standby & periph_standby_run[`SR_TOUCH_BIT] & touch_window_irq)
                    | (in_standby & periph_standby_run[`SR_RTC_BIT] & rtc_irq)
                    | (in_power_down_mode & (pin_irq | addr_match_irq));

  // Sleep state transitions
  always @* begin
    next_state = state;
    case (state)
      ST_ACTIVE: begin
        if (sleep_instr && sleep_arm && is_valid_mode(sleep_mode_select)) begin
          next_state = ST_SLEEPING;
        end
      end
      ST_SLEEPING: begin
        if (wake_event || break_seen) begin
          next_state = ST_WAKING;
        end
      end
      ST_WAKING: begin
        if (wake_count == `WAKE_PCLK_CYCLES && (main_ready || active_mode == `MODE_IDLE)) begin
          next_state = ST_ACTIVE;
        end
      end
      default: next_state = ST_ACTIVE;
    endcase
  end

  // Any reset lands here and restarts in active mode
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state       <= ST_ACTIVE;
      active_mode <= `MODE_IDLE;
      wake_count  <= 3'h0;
      cpu_resume  <= 1'b0;
    end else begin
      state      <= next_state;
      cpu_resume <= (state == ST_WAKING) && (next_state == ST_ACTIVE);
      if (state == ST_ACTIVE && next_state == ST_SLEEPING) begin
        active_mode <= sleep_mode_select;
      end
      if (state != ST_WAKING) begin
        wake_count <= 3'h0;
      end else if (wake_count != `WAKE_PCLK_CYCLES) begin
        wake_count <= wake_count + 3'h1;
      end
    end
  end

  // Clock gating per mode
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_clk_en      <= 1'b1;
      per_clk_en      <= 1'b1;
      rtc_clk_en      <= 1'b1;
      touch_clk_en    <= 1'b1;
      watchdog_clk_en <= 1'b1;
      main_osc_en     <= 1'b1;
      rtc_osc_en      <= 1'b1;
      touch_start     <= 1'b0;
    end else begin
      // CPU enable drops while sleeping or waking; peripheral enable drops only in standby and power-down
      cpu_clk_en      <= ~sleeping & (state != ST_WAKING);
      per_clk_en      <= ~(in_standby | in_power_down_mode);
      rtc_clk_en      <= ~sleeping | in_idle | (in_standby & periph_standby_run[`SR_RTC_BIT]);
      touch_clk_en    <= ~sleeping | in_idle | (in_standby & periph_standby_run[`SR_TOUCH_BIT]);
      watchdog_clk_en <= 1'b1;
      main_osc_en     <= ~sleeping | in_idle | (in_standby & periph_standby_run[`SR_MAIN_BIT]);
      rtc_osc_en      <= ~sleeping | in_idle | (in_standby & periph_standby_run[`SR_RTC_BIT]);
      touch_start     <= in_standby & periph_standby_run[`SR_TOUCH_BIT] & touch_event;
    end
  end

  // Low-power oscillator gate
  osc_edge_counter #(.WIDTH(17)) lp_gate_counter (
    .pclk     (pclk),
    .presetn  (presetn),
    .run      (lp_osc_req & keep_running_in_standby),
    .osc_edge (lp_edge),
    .target   (`LP_GATE_CYCLES),
    .done     (lp_done)
  );

  // Crystal start-up, skipped for an external clock source
  assign startup_target = crystal_source_sel ? 17'h0 : startup_cycles(crystal_startup_select);

  osc_edge_counter #(.WIDTH(17)) xc_startup_counter (
    .pclk     (pclk),
    .presetn  (presetn),
    .run      (crystal_osc_run),
    .osc_edge (xc_edge),
    .target   (startup_target),
    .done     (crystal_osc_stable)
  );

  // Requests must see two crystal edges before the gate opens
  osc_edge_counter #(.WIDTH(17)) xc_gate_counter (
    .pclk     (pclk),
    .presetn  (presetn),
    .run      (any_req & crystal_osc_stable),
    .osc_edge (xc_edge),
    .target   (`XC_GATE_CYCLES),
    .done     (crystal_gate_open)
  );

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lp_osc_gate           <= 1'b0;
      crystal_osc_run       <= 1'b0;
      crystal_grant         <= {NREQ{1'b0}};
      crystal_pins_override <= 1'b0;
    end else begin
      lp_osc_gate           <= lp_done & lp_osc_req;
      crystal_osc_run       <= crystal_enable & (any_req | (standby_run_enable & ~in_power_down_mode));
      crystal_grant         <= crystal_req & {NREQ{crystal_gate_open}};
      crystal_pins_override <= crystal_enable;
    end
  end

endmodule

`default_nettype wire

// *** shared/sleep_defs.vh ***
// Register map, field positions, reset values and timing counts of the sleep and oscillator block
`ifndef SLEEP_DEFS_VH
`define SLEEP_DEFS_VH

// Register byte offsets
`define OFF_SLEEP_CTRL     8'h00
`define OFF_PROTECT_KEY    8'h04
`define OFF_CLOCK_STATUS   8'h0C
`define OFF_LP_OSC_CTRL    8'h18
`define OFF_CRYSTAL_CTRL   8'h1C
`define OFF_STANDBY_RUN    8'h20
`define OFF_SLEEP_STATUS   8'h24

// Sleep control fields
`define SLP_ARM_BIT        0
`define SLP_MODE_LO        1
`define SLP_MODE_HI        2
`define MODE_IDLE          2'h0
`define MODE_STANDBY       2'h1
`define MODE_POWER_DOWN    2'h2

// Crystal control fields
`define XC_ENABLE_BIT      0
`define XC_RUN_BIT         1
`define XC_SEL_BIT         2
`define XC_SUT_LO          4
`define XC_SUT_HI          5
`define XC_RESET           8'h00

// Low power oscillator control
`define LP_RUN_BIT         1

// Clock status fields
`define ST_CRYSTAL_BIT     6
`define ST_LP_BIT          5

// Standby run bits of peripherals
`define SR_MAIN_BIT        0
`define SR_RTC_BIT         1
`define SR_TOUCH_BIT       2
`define SR_UART_BIT        3

// Protection unlock
`define PROTECT_KEY        8'hD8
`define PROTECT_WINDOW     3'h4

// Timing counts, in cycles of the clock named
`define WAKE_PCLK_CYCLES   3'h6
`define LP_GATE_CYCLES     17'h00004
`define XC_GATE_CYCLES     17'h00002
`define XC_STARTUP_1K      1024
`define XC_STARTUP_16K     16384
`define XC_STARTUP_32K     32768
`define XC_STARTUP_64K     65536

`endif

// *** tb/cpu_partner.sv ***
// CPU core and crystal stand-in on the far side of the block
`timescale 1ns/10ps
`default_nettype none
module cpu_partner #(
  parameter HALF = 8
) (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Request from the bench
  input  wire logic exec_sleep,
  // Toward the block
  output logic      sleep_instr,
  output logic      xtal
);
  logic [3:0] cnt;

  // Sleep instruction lasts one cycle; bench arms the block first
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sleep_instr <= 1'b0;
      cnt         <= 4'h0;
      xtal        <= 1'b0;
    end else begin
      sleep_instr <= exec_sleep && !sleep_instr;
      cnt         <= (cnt == HALF - 1) ? 4'h0 : cnt + 4'h1;
      if (cnt == HALF - 1) begin
        xtal <= ~xtal;
      end
    end
  end
endmodule
`default_nettype wire

// *** tb/sleep_osc_checker_assertions.sv ***
// Property checker bound to the sleep and oscillator block
`timescale 1ns/10ps
`default_nettype none
module sleep_osc_checker #(
  parameter NREQ = 4
) (
  // Clock and reset
  input wire logic            pclk,
  input wire logic            presetn,
  // Watched ports
  input wire logic            psel,
  input wire logic            penable,
  input wire logic [7:0]      paddr,
  input wire logic            pready,
  input wire logic            pslverr,
  input wire logic            sleep_instr,
  input wire logic            cpu_clk_en,
  input wire logic            cpu_resume,
  input wire logic            per_clk_en,
  input wire logic            watchdog_clk_en,
  input wire logic            touch_event,
  input wire logic            touch_start,
  input wire logic [NREQ-1:0] crystal_req,
  input wire logic [NREQ-1:0] crystal_grant,
  input wire logic            crystal_osc_run,
  input wire logic            crystal_pins_override
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  apb_ready_a: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  unmapped_err_a: assert property (psel && !penable && paddr == 8'h08 |=> pready && pslverr)
    else $error("no error on unmapped address");
  sleep_entry_a: assert property ($fell(cpu_clk_en) |-> $past(sleep_instr, 2))
    else $error("cpu clock stopped without sleep instruction");
  resume_clk_a: assert property ($rose(cpu_clk_en) |-> $past(cpu_resume))
    else $error("cpu clock back without resume");
  resume_pulse_a: assert property (cpu_resume |=> !cpu_resume)
    else $error("resume longer than one cycle");
  wake_time_a: assert property ($rose(cpu_resume) |-> !$past(cpu_clk_en, 6))
    else $error("wake shorter than six cycles");
  idle_per_a: assert property ($fell(per_clk_en) |-> $fell(cpu_clk_en))
    else $error("peripheral clock stopped outside sleep entry");
  wdt_on_a: assert property (watchdog_clk_en)
    else $error("watchdog clock stopped");
  grant_req_a: assert property ((crystal_grant & ~$past(crystal_req)) == '0)
    else $error("crystal grant without request");
  touch_start_a: assert property (touch_start |-> $past(touch_event))
    else $error("touch start without event");
  run_needs_en_a: assert property (crystal_osc_run |-> crystal_pins_override)
    else $error("crystal running while disabled");

  cover property ($fell(cpu_clk_en));
  cover property ($rose(cpu_resume));
  cover property (|crystal_grant);
  cover property (touch_start);
endmodule

bind sleep_and_crystal_osc_control sleep_osc_checker #(.NREQ(NREQ)) u_chk (
  .pclk, .presetn, .psel, .penable, .paddr, .pready, .pslverr, .sleep_instr,
  .cpu_clk_en, .cpu_resume, .per_clk_en, .watchdog_clk_en, .touch_event,
  .touch_start, .crystal_req, .crystal_grant, .crystal_osc_run, .crystal_pins_override
);
`default_nettype wire

// *** tb/tb_sleep_and_crystal_osc_control.sv ***
// Self-checking bench for the sleep and oscillator block
`timescale 1ns/10ps
`default_nettype none
module tb_sleep_and_crystal_osc_control;
  localparam int XT = 16;
  logic        pclk, presetn, psel, penable, pwrite, any_irq, debug_break;
  logic        touch_event, lp_osc_req, exec, sleep_instr, xtal, pready, pslverr;
  logic        cpu_clk_en, cpu_resume, touch_start, per_clk_en, watchdog_clk_en;
  logic        crystal_osc_run, crystal_pins_override;
  logic        rtc_clk_en, touch_clk_en, main_osc_en, rtc_osc_en, lp_osc_gate;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, v;
  logic [5:0]  wk;
  logic [3:0]  creq, crystal_grant;
  logic [32:0] expq[$];
  int          err_total, num_checks, n;
  int          ms[9] = '{0, 1, 2, 3, 2, 1, 1, 1, 1};
  int          ss[9] = '{6, 2, 0, 0, 1, 3, 4, 5, 7};

  sleep_and_crystal_osc_control #(.STARTUP_1K(4), .STARTUP_16K(8), .STARTUP_32K(12),
    .STARTUP_64K(16)) dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .sleep_instr, .any_irq, .debug_break, .cpu_clk_en, .cpu_resume,
    .pin_irq(wk[0]), .addr_match_irq(wk[1]), .timer_b_irq(wk[2]),
    .uart_sof_irq(wk[3]), .touch_window_irq(wk[4]), .rtc_irq(wk[5]),
    .touch_event, .touch_start, .per_clk_en, .rtc_clk_en, .touch_clk_en,
    .watchdog_clk_en, .main_osc_en, .rtc_osc_en, .main_osc_ready(1'b1),
    .lp_osc_clk(xtal), .lp_osc_req, .lp_osc_gate, .crystal_pin_in(xtal),
    .crystal_req(creq), .crystal_grant, .crystal_osc_run, .crystal_pins_override
  );

  cpu_partner #(.HALF(XT / 2)) partner (
    .pclk, .presetn, .exec_sleep(exec), .sleep_instr, .xtal
  );

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  task automatic chk(input string nm, input logic [32:0] e, input logic [32:0] g);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask

  task close_out;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && k < 20) begin
      @(posedge pclk);
      k++;
    end
    if (k == 20) begin
      err_total++;
      $display("[ERR] pready exp 1 got 0");
    end
    psel <= 1'b0; penable <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic er);
    expq.push_back({er, e});
    apb(1'b0, a, 32'h0);
  endtask

  // Protected write right after the unlock key
  task automatic pw(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, 8'h04, 32'hD8);
    apb(1'b1, a, d);
  endtask

  task automatic slp(input logic [1:0] m, input int s);
    apb(1'b1, 8'h00, {29'h0, m, 1'b1});
    @(posedge pclk) exec <= 1'b1;
    @(posedge pclk) exec <= 1'b0;
    repeat (4) @(posedge pclk);
    chk("cpu_clk_en", m == 2'h3, cpu_clk_en);
    if (m != 2'h3) begin
      chk("per_clk_en", m == 2'h0, per_clk_en);
      chk("xosc_run", m != 2'h2, crystal_osc_run);
      chk("rtc_touch_en", {3{m != 2'h2}}, {rtc_clk_en, touch_clk_en, rtc_osc_en});
      chk("main_osc_en", m == 2'h0 || (m == 2'h1 && v[0]), main_osc_en);
      if (m == 2'h2) begin
        wk[2] <= 1'b1;
        repeat (10) @(posedge pclk);
        chk("pd_asleep", 1'b0, cpu_clk_en);
      end
      if (m == 2'h1 && s == 2) begin
        touch_event <= 1'b1;
        repeat (3) @(posedge pclk);
        chk("touch_start", 1'b1, touch_start);
        chk("stby_asleep", 1'b0, cpu_clk_en);
        touch_event <= 1'b0;
      end
      n = 0;
      if (s == 7) debug_break <= 1'b1;
      else if (s == 6) any_irq <= 1'b1;
      else wk[s] <= 1'b1;
      while (cpu_resume !== 1'b1 && n < 200) begin
        @(posedge pclk);
        n++;
      end
      chk("wake_cycles", 1'b1, n >= 6 && n < 200);
      any_irq <= 1'b0; debug_break <= 1'b0; wk <= 6'h0;
    end
  endtask

  // Read results are compared against the oldest expectation
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite && expq.size() > 0) begin
      chk("prdata", expq.pop_front(), {pslverr, prdata});
    end
  end

  initial begin
    #(100 * 20000);
    err_total++;
    close_out;
  end

  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h0;
    pwdata = 32'h0; any_irq = 1'b0; debug_break = 1'b0; touch_event = 1'b0;
    lp_osc_req = 1'b0; exec = 1'b0; wk = 6'h0; creq = 4'h0;
    void'($urandom(32'hAC71));
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rd(8'h1C, 32'h0, 1'b0);
    rd(8'h08, 32'h0, 1'b1);
    rd(8'h00, 32'h0, 1'b0);
    apb(1'b1, 8'h1C, 32'h35);
    rd(8'h1C, 32'h34, 1'b0);
    pw(8'h1C, 32'h35);
    rd(8'h1C, 32'h35, 1'b0);
    chk("pins_override", 1'b1, crystal_pins_override);
    pw(8'h1C, 32'h03);
    rd(8'h1C, 32'h37, 1'b0);
    chk("xosc_run", 1'b1, crystal_osc_run);
    creq <= 4'h1;
    n = 0;
    while (crystal_grant !== 4'h1 && n < 500) begin
      @(posedge pclk);
      n++;
    end
    chk("grant", 4'h1, crystal_grant);
    rd(8'h0C, 32'h40, 1'b0);
    creq <= 4'h0;
    @(posedge pclk);
    creq <= 4'h4;
    n = 0;
    while (crystal_grant !== 4'h4 && n < 500) begin
      @(posedge pclk);
      n++;
    end
    chk("grant_delay", 1'b1, n >= XT && n <= 3 * XT + 4);
    creq <= 4'h0;
    v = $urandom;
    apb(1'b1, 8'h20, {28'h0, v[3:0] | 4'hE});
    rd(8'h20, {28'h0, v[3:0] | 4'hE}, 1'b0);
    for (int i = 0; i < 9; i++) slp(ms[i][1:0], ss[i]);
    // Kept-running low-power oscillator opens its gate after four of its edges
    pw(8'h18, 32'h2);
    lp_osc_req <= 1'b1;
    n = 0;
    while (lp_osc_gate !== 1'b1 && n < 500) begin
      @(posedge pclk);
      n++;
    end
    chk("lp_gate_delay", 1'b1, n > 3 * XT - 4 && n <= 4 * XT + 8);
    rd(8'h0C, 32'h60, 1'b0);
    apb(1'b1, 8'h00, 32'h5);
    @(posedge pclk) exec <= 1'b1;
    @(posedge pclk) exec <= 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("reset_wake", 1'b1, cpu_clk_en);
    rd(8'h1C, 32'h0, 1'b0);
    repeat (2) @(posedge pclk);
    close_out;
  end
endmodule
`default_nettype wire
